// File: include/sms_pkg.sv
// shared constants and types of the standby mode sequencer
package sms_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_WD_CSR   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_WD_COUNT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_WD_RST   = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h4;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned CTRL_STANDBY_SELECT_BIT = 0;
    localparam int unsigned CTRL_WAKE_EDGE_BIT      = 1;
    localparam int unsigned CTRL_W                  = 2;
    localparam int unsigned WD_FLAG_BIT             = 7;
    localparam int unsigned WD_MODE_BIT             = 6;
    localparam int unsigned WD_RUN_BIT              = 5;
    localparam int unsigned WD_RESET_LSB            = 5;
    localparam int unsigned WD_SEL_MSB              = 2;
    localparam int unsigned WD_SEL_LSB              = 0;
    localparam int unsigned WD_SEL_W                = 3;
    localparam int unsigned STATUS_PIN_BIT          = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST     = 2'h0;
    localparam logic [DATA_W-1:0] WD_CSR_RST   = 8'h00;
    localparam logic [DATA_W-1:0] WD_COUNT_RST = 8'h00;
    localparam logic [DATA_W-1:0] WD_RST_RST   = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO    = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // wake edge encodings and timing
    localparam logic EDGE_FALL = 1'b0;
    localparam logic EDGE_RISE = 1'b1;
    localparam int unsigned BLOCK_W            = 3;
    localparam logic [BLOCK_W-1:0] NMI_BLOCK_CYCLES = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // per-unit initialise strobes
    localparam int unsigned INIT_MTU_CTRL = 0;
    localparam int unsigned INIT_FRT      = 1;
    localparam int unsigned INIT_SCIF     = 2;
    localparam int unsigned INIT_MAC      = 3;
    localparam int unsigned INIT_MAC_DMA  = 4;
    localparam int unsigned INIT_W        = 5;

    typedef enum logic [3:0] {
        SMS_RUN    = 4'h1,
        SMS_SLEEP  = 4'h2,
        SMS_STBY   = 4'h4,
        SMS_SETTLE = 4'h8
    } sms_state_t;

endpackage

// File: verilog/sms_wake_timer.sv
// watchdog counter with prescaler, times the settling interval
`timescale 1ns/10ps
`default_nettype none

module sms_wake_timer #(
    parameter int unsigned CNT_W = 8,
    parameter int unsigned PRE_W = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             run_in,
    input  wire logic [2:0]       div_sel_in,
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] load_value_in,
    output logic      [CNT_W-1:0] count_out,
    output logic                  overflow_out
);

    // largest division is two to the eighth, needs eight prescaler bits
    if (PRE_W < 8 || CNT_W < 1) begin : g_bad_width
        $error("sms_wake_timer: PRE_W must be at least 8");
    end

    logic [PRE_W-1:0] prescale;
    logic [PRE_W-1:0] mask;
    logic             tick;

    assign mask         = ~({PRE_W{1'b1}} << ({1'b0, div_sel_in} + 4'h1));
    assign tick         = run_in && ((prescale & mask) == mask);
    assign overflow_out = tick && (count_out == {CNT_W{1'b1}});

    ////////////////////////////////////////////////////////////////////////////
    // prescaler restarts when idle so every interval is whole
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prescale <= '0;
        end else if (!run_in) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // count is retained across standby, never cleared by entry
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_out <= '0;
        end else if (load_in) begin
            count_out <= load_value_in;
        end else if (tick) begin
            count_out <= count_out + 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: verilog/sms_sequencer.sv
// standby mode sequencer: entry, retention policy, wake and settling
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - standby select set plus low-power instruction moves execution into standby
// - wake edge ignored in the instruction cycle and five cycles after it
// - standby stops both cpu and peripheral clock enables
// - cpu is only clock-gated, its registers are never reset here
// - entry pulses reset of transfer unit channel control and operation registers
// - transfer unit address, count, request and vector registers get no reset
// - entry clears watchdog status bits seven to five and reset status register
// - watchdog select bits two to zero and watchdog count are kept
// - entry pulses reset of timer, fifo serial, network mac and its engine
// - other units receive no reset strobe and keep their registers
// - control register and frequency settings are not touched by entry
// - standby ends only by wake edge, power-on reset or manual reset
// - wake edge waits watchdog interval, then clocks return and interrupt starts
// - standby select clear makes the instruction enter light sleep instead
// - wake edge select zero picks falling edge, one picks rising edge
module sms_sequencer
    import sms_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              manual_reset_b_in,
    input  wire logic              sleep_exec_in,
    input  wire logic              irq_wake_in,
    input  wire logic              wake_pin_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [DATA_W-1:0] rd_data_out,
    output logic                   cpu_clk_en_out,
    output logic                   periph_clk_en_out,
    output logic                   standby_out,
    output logic                   sleep_out,
    output logic                   nmi_take_out,
    output logic      [INIT_W-1:0] unit_init_out
);

    if (CNT_W != DATA_W) begin : g_bad_cnt
        $error("sms_sequencer: CNT_W must equal the register data width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    sms_state_t          state;
    sms_state_t          next_state;
    logic [CTRL_W-1:0]   ctrl;
    logic [DATA_W-1:0]   wd_csr;
    logic [DATA_W-1:0]   wd_rst;
    logic [BLOCK_W-1:0]  block_cnt;
    logic                pin_prev;
    logic                edge_seen;
    logic                nmi_ok;
    logic                enter_standby;
    logic                enter_sleep;
    logic                timer_run;
    logic                timer_load;
    logic [CNT_W-1:0]    wd_count;
    logic                wd_overflow;
    logic                wr_ctrl;
    logic                wr_csr;
    logic                wr_rst;
    logic                next_take;

    assign wr_ctrl = wr_in && (addr_in == ADDR_CTRL);
    assign wr_csr  = wr_in && (addr_in == ADDR_WD_CSR);
    assign wr_rst  = wr_in && (addr_in == ADDR_WD_RST);
    assign timer_load = wr_in && (addr_in == ADDR_WD_COUNT);

    ////////////////////////////////////////////////////////////////////////////
    // wake edge detection; the pin is taken as synchronous to clk_in
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= wake_pin_in;
        end
    end

    always_comb begin
        if (ctrl[CTRL_WAKE_EDGE_BIT] == EDGE_RISE) begin
            edge_seen = wake_pin_in && !pin_prev;
        end else begin
            edge_seen = !wake_pin_in && pin_prev;
        end
    end

    // an edge inside the blocking window is dropped, not held pending
    assign nmi_ok = edge_seen && (block_cnt == '0) && !sleep_exec_in;

    ////////////////////////////////////////////////////////////////////////////
    // blocking window after the low-power instruction
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            block_cnt <= '0;
        end else if (!manual_reset_b_in) begin
            block_cnt <= '0;
        end else if (sleep_exec_in && (state == SMS_RUN)) begin
            block_cnt <= NMI_BLOCK_CYCLES;
        end else if (block_cnt != '0) begin
            block_cnt <= block_cnt - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode selection at the low-power instruction
    assign enter_standby = (state == SMS_RUN) && sleep_exec_in
                           && ctrl[CTRL_STANDBY_SELECT_BIT];
    assign enter_sleep   = (state == SMS_RUN) && sleep_exec_in
                           && !ctrl[CTRL_STANDBY_SELECT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        next_state = state;
        next_take  = 1'b0;
        unique case (state)
            SMS_RUN: begin
                if (enter_standby) begin
                    next_state = SMS_STBY;
                end else if (enter_sleep) begin
                    next_state = SMS_SLEEP;
                end else if (nmi_ok) begin
                    next_take = 1'b1;
                end
            end
            SMS_SLEEP: begin
                if (nmi_ok) begin
                    next_state = SMS_RUN;
                    next_take  = 1'b1;
                end else if (irq_wake_in) begin
                    next_state = SMS_RUN;
                end
            end
            SMS_STBY: begin
                // nothing but the selected wake edge leaves this state
                if (nmi_ok) begin
                    next_state = SMS_SETTLE;
                end
            end
            SMS_SETTLE: begin
                if (wd_overflow) begin
                    next_state = SMS_RUN;
                    next_take  = 1'b1;
                end
            end
        endcase
    end

    // manual reset cancels any low-power mode; power-on reset is rst_b_in
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= SMS_RUN;
        end else if (!manual_reset_b_in) begin
            state <= SMS_RUN;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock enables and mode flags, registered from the next state
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cpu_clk_en_out    <= 1'b1;
            periph_clk_en_out <= 1'b1;
            standby_out       <= 1'b0;
            sleep_out         <= 1'b0;
        end else if (!manual_reset_b_in) begin
            cpu_clk_en_out    <= 1'b1;
            periph_clk_en_out <= 1'b1;
            standby_out       <= 1'b0;
            sleep_out         <= 1'b0;
        end else begin
            // cpu state is only frozen by its clock, never cleared
            cpu_clk_en_out    <= (next_state == SMS_RUN);
            periph_clk_en_out <= (next_state == SMS_RUN)
                                 || (next_state == SMS_SLEEP);
            standby_out       <= (next_state == SMS_STBY)
                                 || (next_state == SMS_SETTLE);
            sleep_out         <= (next_state == SMS_SLEEP);
        end
    end

    // interrupt exception start, one cycle, coincides with clock return
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            nmi_take_out <= 1'b0;
        end else begin
            nmi_take_out <= next_take && manual_reset_b_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // initialise strobes to the units that lose their state in standby;
    // units with no strobe bit keep everything
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            unit_init_out <= '0;
        end else begin
            unit_init_out                <= '0;
            unit_init_out[INIT_MTU_CTRL] <= enter_standby && manual_reset_b_in;
            unit_init_out[INIT_FRT]      <= enter_standby && manual_reset_b_in;
            unit_init_out[INIT_SCIF]     <= enter_standby && manual_reset_b_in;
            unit_init_out[INIT_MAC]      <= enter_standby && manual_reset_b_in;
            unit_init_out[INIT_MAC_DMA]  <= enter_standby && manual_reset_b_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register: kept across standby
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= wr_data_in[CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog control/status: upper bits cleared at entry, select bits kept
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wd_csr <= WD_CSR_RST;
        end else if (enter_standby && manual_reset_b_in) begin
            wd_csr[DATA_W-1:WD_RESET_LSB] <= '0;
        end else begin
            if (wr_csr) begin
                wd_csr[WD_MODE_BIT:0] <= wr_data_in[WD_MODE_BIT:0];
            end
            // overflow flag: software writes 0 to clear, a new overflow wins
            if (wd_overflow && (state == SMS_RUN)) begin
                wd_csr[WD_FLAG_BIT] <= 1'b1;
            end else if (wr_csr && !wr_data_in[WD_FLAG_BIT]) begin
                wd_csr[WD_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // watchdog reset control/status: wholly cleared at entry
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wd_rst <= WD_RST_RST;
        end else if (enter_standby && manual_reset_b_in) begin
            wd_rst <= WD_RST_RST;
        end else if (wr_rst) begin
            wd_rst <= wr_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settling timer: the kept count runs at the kept division to overflow;
    // a short programmed interval gives an unstable clock, software must size it
    assign timer_run = (state == SMS_SETTLE)
                       || ((state == SMS_RUN) && wd_csr[WD_RUN_BIT]);

    sms_wake_timer #(
        .CNT_W (CNT_W),
        .PRE_W (8)
    ) u_timer (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .run_in        (timer_run),
        .div_sel_in    (wd_csr[WD_SEL_MSB:WD_SEL_LSB]),
        .load_in       (timer_load),
        .load_value_in (wr_data_in[CNT_W-1:0]),
        .count_out     (wd_count),
        .overflow_out  (wd_overflow)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read port: data stand in the cycle after the strobe only
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= READ_ZERO;
        end else if (!rd_in) begin
            rd_data_out <= READ_ZERO;
        end else begin
            unique case (addr_in)
                ADDR_CTRL:     rd_data_out <= {{(DATA_W-CTRL_W){1'b0}}, ctrl};
                ADDR_WD_CSR:   rd_data_out <= wd_csr;
                ADDR_WD_COUNT: rd_data_out <= wd_count;
                ADDR_WD_RST:   rd_data_out <= wd_rst;
                ADDR_STATUS:   rd_data_out <= {3'h0, pin_prev, state};
                default:       rd_data_out <= READ_ZERO;
            endcase
        end
    end

endmodule

`default_nettype wire

// File: sim/sms_sequencer_asserts.sv
// port-level checks of the standby mode sequencer
`timescale 1ns/10ps
`default_nettype none
module sms_sequencer_asserts
    import sms_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input wire logic              clk_in,
    input wire logic              rst_b_in,
    input wire logic              manual_reset_b_in,
    input wire logic              sleep_exec_in,
    input wire logic              irq_wake_in,
    input wire logic              wake_pin_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [DATA_W-1:0] rd_data_out,
    input wire logic              cpu_clk_en_out,
    input wire logic              periph_clk_en_out,
    input wire logic              standby_out,
    input wire logic              sleep_out,
    input wire logic              nmi_take_out,
    input wire logic [INIT_W-1:0] unit_init_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_entry;
        $rose(standby_out);
    endsequence
    sequence s_blocked;
        !nmi_take_out [*6];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_entry_needs_exec: assert property (s_entry |-> $past(sleep_exec_in))
        else $error("standby entered without the low-power instruction");
    a_entry_inits_units: assert property (s_entry |-> unit_init_out == 5'h1f)
        else $error("unit initialise pulse missing at standby entry");
    a_init_only_entry: assert property (unit_init_out != 5'h00 |-> s_entry)
        else $error("unit initialise pulse outside standby entry");
    a_standby_gated: assert property (standby_out |-> !cpu_clk_en_out && !periph_clk_en_out)
        else $error("clock enabled while in standby");
    a_nmi_blocked: assert property (sleep_exec_in && cpu_clk_en_out |=> s_blocked)
        else $error("wake edge taken inside the blocking window");
    a_exit_only_wake: assert property ($fell(standby_out) |-> nmi_take_out || !$past(manual_reset_b_in))
        else $error("standby left without wake edge or reset");
    a_wake_restores: assert property (nmi_take_out |-> cpu_clk_en_out && periph_clk_en_out && !standby_out)
        else $error("interrupt start without clocks restored");
    a_sleep_keeps_periph: assert property (sleep_out |-> periph_clk_en_out && !cpu_clk_en_out && !standby_out)
        else $error("light sleep with wrong clock enables");
endmodule
`default_nettype wire

// File: sim/sms_nmi_source.sv
// model of the external wake pin source
`timescale 1ns/10ps
`default_nettype none
module sms_nmi_source (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic edge_rise_in,
    input  wire logic wake_req_in,
    input  wire logic clk_run_in,
    output logic      pin_out
);
    logic [1:0] hold;
    logic       run_q;
    logic       restart;
    // the wake level must outlive the clock restart, not end with it
    assign restart = clk_run_in && !run_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_out <= 1'b1;
            hold    <= 2'h0;
            run_q   <= 1'b1;
        end else begin
            run_q <= clk_run_in;
            // wake level held 3 cycles after the clock restarts
            if (restart) begin
                hold <= 2'h3;
            end else if (hold != 2'h0) begin
                hold <= hold - 2'h1;
            end
            if (wake_req_in) begin
                pin_out <= edge_rise_in;
            end else if (hold == 2'h0 && !restart) begin
                pin_out <= !edge_rise_in;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/sms_sequencer_bench.sv
// self-checking bench of the standby mode sequencer
`timescale 1ns/10ps
`default_nettype none
module sms_sequencer_bench;
    import sms_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, man_b = 1'b1, sleep_exec = 1'b0, irq = 1'b0;
    logic wake_req = 1'b0, edge_rise = 1'b0, wr = 1'b0, rd = 1'b0, pin;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rd_data, c, csr;
    logic cpu_en, per_en, stby, slp, nmi;
    logic [4:0] uinit;
    int err_count = 0, checks = 0, cyc = 0, n, t;
    int seed = 32'ha222ec0d;
    always #12.5 clk = ~clk;
    sms_sequencer #(.CNT_W(8)) i_sms_sequencer (
        .clk_in(clk), .rst_b_in(rst_b), .manual_reset_b_in(man_b),
        .sleep_exec_in(sleep_exec), .irq_wake_in(irq), .wake_pin_in(pin),
        .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
        .rd_data_out(rd_data), .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
        .standby_out(stby), .sleep_out(slp), .nmi_take_out(nmi), .unit_init_out(uinit));
    sms_nmi_source i_sms_nmi_source (.clk_in(clk), .rst_b_in(rst_b),
        .edge_rise_in(edge_rise), .wake_req_in(wake_req), .clk_run_in(cpu_en), .pin_out(pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(what, rd_data, exp);
    endtask
    task automatic exec_sleep;
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
    endtask
    function automatic logic [7:0] status_exp(input logic [3:0] st, input logic p);
        return {3'h0, p, st};
    endfunction
    // settling clock cycles until the kept count overflows
    function automatic int settle_len(input logic [7:0] cnt, input logic [7:0] sel);
        return (256 - int'(cnt)) << (int'(sel[2:0]) + 1);
    endfunction
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk("ctrl", ADDR_CTRL, 8'h00);
        rd_chk("wd_csr", ADDR_WD_CSR, 8'h00);
        rd_chk("wd_rst", ADDR_WD_RST, 8'h00);
        rd_chk("status", ADDR_STATUS, status_exp(4'h1, 1'b1));
        wr_reg(4'h9, 8'ha5);
        rd_chk("unmapped", 4'h9, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = 8'($random(seed));
            wr_reg(ADDR_WD_RST, c);
            rd_chk("wd_rst", ADDR_WD_RST, c);
            wr_reg(ADDR_CTRL, c);
            rd_chk("ctrl", ADDR_CTRL, {6'h00, c[1:0]});
        end
        // standby with each wake edge, edge first sent inside the blocking window
        for (int m = 0; m < 2; m++) begin
            edge_rise <= m[0];
            c = 8'he0 | 8'($random(seed) & 8'h18);
            csr = 8'h40 | 8'($random(seed) & 8'h1b);
            t = settle_len(c, csr);
            repeat (6) @(posedge clk);
            wr_reg(ADDR_CTRL, {6'h00, m[0], 1'b1});
            wr_reg(ADDR_WD_CSR, csr);
            wr_reg(ADDR_WD_COUNT, c);
            wr_reg(ADDR_WD_RST, 8'h5a);
            exec_sleep();
            wake_req <= 1'b1;
            #1 check("unit_init", {3'h0, uinit}, 8'h1f);
            check("enables", {5'h0, cpu_en, per_en, stby}, 8'h01);
            rd_chk("wd_csr", ADDR_WD_CSR, csr & 8'h1f);
            rd_chk("wd_rst", ADDR_WD_RST, 8'h00);
            rd_chk("wd_count", ADDR_WD_COUNT, c);
            rd_chk("ctrl", ADDR_CTRL, {6'h00, m[0], 1'b1});
            @(posedge clk);
            irq <= 1'b1;
            wake_req <= 1'b0;
            @(posedge clk);
            irq <= 1'b0;
            repeat (4) @(posedge clk);
            rd_chk("blocked", ADDR_STATUS, status_exp(4'h4, pin));
            wake_req <= 1'b1;
            repeat (3) @(posedge clk);
            rd_chk("settle", ADDR_STATUS, status_exp(4'h8, pin));
            n = 6;
            while (nmi !== 1'b1 && n < 5000) begin
                @(posedge clk);
                n++;
                #1;
            end
            wake_req <= 1'b0;
            check("settle_time", 8'(n >= t && n <= t + 6), 8'h01);
            check("wake", {5'h0, cpu_en, per_en, stby}, 8'h06);
        end
        // let the partner's held wake level run out first
        repeat (8) @(posedge clk);
        // light sleep, ended by an ordinary interrupt
        wr_reg(ADDR_CTRL, 8'h00);
        exec_sleep();
        #1 check("sleep", {4'h0, slp, cpu_en, per_en, stby}, 8'h0a);
        check("sleep_init", {3'h0, uinit}, 8'h00);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        @(posedge clk);
        #1 check("sleep_end", {6'h0, slp, cpu_en}, 8'h01);
        // manual reset cancels standby and keeps control
        wr_reg(ADDR_CTRL, 8'h01);
        exec_sleep();
        man_b <= 1'b0;
        @(posedge clk);
        man_b <= 1'b1;
        #1 check("manual", {6'h0, cpu_en, stby}, 8'h02);
        rd_chk("ctrl_kept", ADDR_CTRL, 8'h01);
        // power-on reset in standby: clocks back, control cleared
        exec_sleep();
        @(posedge clk);
        #1 check("por_entry", {7'h0, stby}, 8'h01);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1 check("por", {6'h0, cpu_en, stby}, 8'h02);
        rd_chk("ctrl_por", ADDR_CTRL, 8'h00);
        final_report();
    end
endmodule
bind sms_sequencer sms_sequencer_asserts #(.CNT_W(CNT_W)) u_chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .manual_reset_b_in(manual_reset_b_in),
    .sleep_exec_in(sleep_exec_in), .irq_wake_in(irq_wake_in), .wake_pin_in(wake_pin_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out), .standby_out(standby_out), .sleep_out(sleep_out),
    .nmi_take_out(nmi_take_out), .unit_init_out(unit_init_out));
`default_nettype wire
